// ===== design/modem_ctl_pkg.sv
/*
 * Shared constants for the modem interchange control block: pin indices of the
 * synchronised input vector, response and clamp times in milliseconds, data rates
 * and the scrambler guard count.
 * Assumes a single 25 MHz system clock; cycle counts are derived in the modules.
 */
package modem_ctl_pkg;

    // ----------------------------------------------------------------
    // clock and rates
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 32'h017D_7840;  // 25 MHz
    localparam int unsigned MS_PER_S = 32'h0000_03E8;
    localparam int unsigned FULL_BPS = 32'h0000_12C0;    // 4800 bit/s
    localparam int unsigned RED_BPS = 32'h0000_0960;     // 2400 bit/s
    localparam int CYC_W = 16;                          // width of cycle counters
    localparam int MS_W = 10;                           // width of millisecond counters

    // ----------------------------------------------------------------
    // times in milliseconds
    // ----------------------------------------------------------------
    localparam logic [MS_W-1:0] ON_SHORT_FULL_MS = 10'h019;  // 25 ms
    localparam logic [MS_W-1:0] ON_LONG_FULL_MS = 10'h2C4;   // 708 ms
    localparam logic [MS_W-1:0] ON_SHORT_RED_MS = 10'h043;   // 67 ms
    localparam logic [MS_W-1:0] ON_LONG_RED_MS = 10'h3B0;    // 944 ms
    localparam logic [MS_W-1:0] TURNOFF_MS = 10'h019;        // 25 ms turn-off sequence
    localparam logic [MS_W-1:0] RLSD_OFF_MS = 10'h00A;       // inside the 5..15 ms window
    localparam logic [MS_W-1:0] BACK_ON_MS = 10'h078;        // inside the 80..160 ms window
    localparam logic [MS_W-1:0] BACK_DET_ON_MS = 10'h028;    // below 80 ms
    localparam logic [MS_W-1:0] BACK_DET_OFF_MS = 10'h028;   // inside the 15..80 ms window
    localparam logic [MS_W-1:0] CLAMP_EXT_MS = 10'h096;      // 150 ms
    localparam logic [MS_W-1:0] MS_SAT = 10'h3FF;            // counter saturation value, also the reset value of clamp_ms and bclamp_ms

    // ----------------------------------------------------------------
    // scrambler
    // ----------------------------------------------------------------
    localparam int HIST_W = 12;
    localparam logic [5:0] GUARD_COUNT = 6'h20;  // coincidences before inversion

    // ----------------------------------------------------------------
    // indices of the synchronised pin vector
    // ----------------------------------------------------------------
    localparam int P_TXD = 0;
    localparam int P_RTS = 1;
    localparam int P_RTS_F = 2;
    localparam int P_CON = 3;
    localparam int P_CON_F = 4;
    localparam int P_RATE = 5;
    localparam int P_EXTCLK = 6;
    localparam int P_SEQ = 7;
    localparam int P_2W = 8;
    localparam int P_CLEXT = 9;
    localparam int P_EXTSEL = 10;
    localparam int P_BTXD = 11;
    localparam int P_BREQ = 12;
    localparam int P_BCLEXT = 13;
    localparam int PIN_W = 14;

    typedef enum logic [1:0] {ST_IDLE, ST_TRAIN, ST_DATA, ST_TURNOFF} seq_state_t;

endpackage

// ===== design/modem_interchange_control.sv
/*
 * Interchange control for a leased-line 4800/2400 bit/s modem: ready-for-sending
 * sequencing, detector response times, half-duplex clamps, element timing and the
 * scrambler paths between terminal and modulator/demodulator.
 * Assumes terminal pins are asynchronous; datapath signals share SYS_CLK.
 */
`timescale 1ns/1ps
// Function
// R1 - detector on after sync, before received data
// R2 - ready-for-sending after 25/708 or 67/944 ms
// R3 - ready off within 2 ms; detector 5-15 ms
// R4 - backward ready and detector response windows
// R5 - two-wire: clamp received data, detector, extension
// R6 - two-wire: clamp backward data and detector
// R7 - faulted request or connect reads OFF
// R8 - terminal treats faulted data-set-ready OFF
// R9 - drive transmit and receive element timing
// R10 - optional external transmit timing from terminal
// R11 - rate selector picks full or reduced rate
// R12 - backward circuits only when channel fitted
// R13 - scrambler and descrambler, 1+x^-6+x^-7
// R14 - guard breaks repeating output patterns
// R15 - ready on after training, then user data
// R16 - request during turn-off waits for end
// R17 - sequence select picks ready delay
// R18 - intervals counted from system clock
module modem_interchange_control
    import modem_ctl_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = SYS_CLK_HZ / MS_PER_S,
    parameter int unsigned BIT_CYC_FULL = SYS_CLK_HZ / FULL_BPS,
    parameter int unsigned BIT_CYC_RED = SYS_CLK_HZ / RED_BPS,
    parameter logic [MS_W-1:0] BACK_CLAMP_MS = CLAMP_EXT_MS,
    parameter bit BACK_FITTED = 1'b1,
    parameter int FIFO_DEPTH = 4
)
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic TX_DATA,
    input wire logic RTS,
    input wire logic RTS_FAULT,
    input wire logic CONNECT,
    input wire logic CONNECT_FAULT,
    input wire logic RATE_FULL,
    input wire logic EXT_TX_CLK,
    input wire logic SEQ_LONG,
    input wire logic TWO_WIRE,
    input wire logic CLAMP_EXT_EN,
    input wire logic EXT_CLK_SEL,
    input wire logic BACK_TX_DATA,
    input wire logic BACK_REQ,
    input wire logic BACK_CLAMP_EN,
    output logic RX_DATA,
    output logic CTS,
    output logic DSR,
    output logic RLSD,
    output logic TX_CLK,
    output logic RX_CLK,
    output logic BACK_RX_DATA,
    output logic BACK_READY,
    output logic BACK_RLSD,
    input wire logic LINE_SIGNAL,
    input wire logic SYNC_DONE,
    input wire logic RX_BIT_VALID,
    input wire logic RX_BIT,
    input wire logic BACK_LINE_SIGNAL,
    input wire logic BACK_RX_VALID,
    input wire logic BACK_RX_BIT,
    output logic TX_ACTIVE,
    output logic TX_LINE_VALID,
    output logic TX_LINE_BIT,
    input wire logic TX_LINE_READY,
    output logic BACK_TX_BIT
);
    localparam logic [CYC_W-1:0] MS_LAST = CYC_W'(CYCLES_PER_MS - 1);
    localparam logic [CYC_W-1:0] FULL_LAST = CYC_W'(BIT_CYC_FULL - 1);
    localparam logic [CYC_W-1:0] RED_LAST = CYC_W'(BIT_CYC_RED - 1);

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic ext_prev;
        seq_state_t st;
        logic [MS_W-1:0] seq_ms;
        logic [CYC_W-1:0] ms_cyc;
        logic ms_tick;
        logic [CYC_W-1:0] bit_cyc;
        logic tx_clk;
        logic [CYC_W-1:0] rx_cyc;
        logic rx_clk;
        logic cts;
        logic dsr;
        logic rlsd;
        logic [MS_W-1:0] lost_ms;
        logic [MS_W-1:0] clamp_ms;
        logic rx_data;
        logic back_ready;
        logic [MS_W-1:0] b121_ms;
        logic back_rlsd;
        logic [MS_W-1:0] b122_ms;
        logic [MS_W-1:0] bclamp_ms;
        logic back_rx_data;
        logic back_tx_bit;
    } ctl_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // saturating millisecond counter, cleared on request
    function automatic logic [MS_W-1:0] ms_step(input logic [MS_W-1:0] cnt, input logic clr, input logic tick);
        if (clr)
            return '0;
        else if (tick && cnt != MS_SAT)
            return cnt + 1'b1;
        else
            return cnt;
    endfunction

    // ready-for-sending delay for the chosen sequence and rate
    function automatic logic [MS_W-1:0] turn_on_ms(input logic long_seq, input logic full);
        case ({long_seq, full})
            2'b01: return ON_SHORT_FULL_MS;
            2'b11: return ON_LONG_FULL_MS;
            2'b00: return ON_SHORT_RED_MS;
            default: return ON_LONG_RED_MS;
        endcase
    endfunction

    ctl_t s;
    ctl_t next_s;
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [PIN_W-1:0] p;
    logic rts_eff;
    logic con_eff;
    logic clamp;
    logic bclamp;
    logic [CYC_W-1:0] bit_last;
    logic int_tick;
    logic ext_rise;
    logic tx_take;
    logic scr_out;
    logic descr_out;

    stream_if #(.W(1)) tx_in ();
    stream_if #(.W(1)) tx_out ();

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------

    // release through two flops; assertion stays asynchronous
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    // ----------------------------------------------------------------
    // datapath submodules
    // ----------------------------------------------------------------

    sync_scrambler #(.DESCR(1'b0)) u_scr (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .en(tx_take & tx_in.ready),
        .din((s.st == ST_DATA) ? p[P_TXD] : 1'b1),  // see R15
        .dout(scr_out)
    );

    sync_scrambler #(.DESCR(1'b1)) u_descr (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .en(RX_BIT_VALID),
        .din(RX_BIT),
        .dout(descr_out)
    );

    stream_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .in_s(tx_in.snk),
        .out_s(tx_out.src)
    );

    // transmit stream towards the modulator; a full FIFO holds the scrambler
    assign tx_in.valid = tx_take;
    assign tx_in.data = scr_out;
    assign tx_out.ready = TX_LINE_READY;
    assign TX_LINE_VALID = tx_out.valid;
    assign TX_LINE_BIT = tx_out.data;

    // ----------------------------------------------------------------
    // decoded conditions
    // ----------------------------------------------------------------

    // faulted request or connect lines read as OFF
    assign p = s.sync2;
    assign con_eff = p[P_CON] & ~p[P_CON_F];  // see R7
    assign rts_eff = p[P_RTS] & ~p[P_RTS_F] & con_eff;  // see R7

    // half-duplex clamps with optional extension after release
    assign clamp = p[P_2W] & (rts_eff | (p[P_CLEXT] & (s.clamp_ms < CLAMP_EXT_MS)));  // see R5
    assign bclamp = p[P_2W] & (p[P_BREQ] | (p[P_BCLEXT] & (s.bclamp_ms < BACK_CLAMP_MS)));  // see R6

    // bit timing from the internal divider or the terminal's clock
    assign bit_last = p[P_RATE] ? FULL_LAST : RED_LAST;  // see R11
    assign int_tick = (s.bit_cyc >= bit_last);
    assign ext_rise = p[P_EXTCLK] & ~s.ext_prev;
    assign tx_take = p[P_EXTSEL] ? ext_rise : int_tick;  // see R10

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    always_comb
    begin
        next_s = s;
        // two-flop pin synchronisers and external clock edge memory
        next_s.sync1 = {BACK_CLAMP_EN, BACK_REQ, BACK_TX_DATA, EXT_CLK_SEL, CLAMP_EXT_EN, TWO_WIRE, SEQ_LONG,
                        EXT_TX_CLK, RATE_FULL, CONNECT_FAULT, CONNECT, RTS_FAULT, RTS, TX_DATA};
        next_s.sync2 = s.sync1;
        next_s.ext_prev = p[P_EXTCLK];

        // one millisecond tick
        next_s.ms_tick = (s.ms_cyc >= MS_LAST);  // see R18
        next_s.ms_cyc = next_s.ms_tick ? '0 : s.ms_cyc + 1'b1;

        // transmit element timing, high in the first half of each bit
        next_s.bit_cyc = int_tick ? '0 : s.bit_cyc + 1'b1;
        next_s.tx_clk = (next_s.bit_cyc <= (bit_last >> 1));  // see R9

        // receive element timing, restarted by each received bit
        if (RX_BIT_VALID)
            next_s.rx_cyc = '0;
        else if (s.rx_cyc != '1)
            next_s.rx_cyc = s.rx_cyc + 1'b1;
        next_s.rx_clk = (next_s.rx_cyc <= (bit_last >> 1));  // see R9

        // turn-on / turn-off sequencer
        case (s.st)
            ST_IDLE:
            begin
                next_s.seq_ms = '0;
                if (rts_eff)
                    next_s.st = ST_TRAIN;
            end
            ST_TRAIN:
            begin
                next_s.seq_ms = ms_step(s.seq_ms, 1'b0, s.ms_tick);  // see R18
                if (!rts_eff)
                    next_s.st = ST_IDLE;
                else if (s.seq_ms > turn_on_ms(p[P_SEQ], p[P_RATE]))  // see R2, R17
                    next_s.st = ST_DATA;  // see R15
            end
            ST_DATA:
            begin
                next_s.seq_ms = '0;
                if (!rts_eff)
                    next_s.st = ST_TURNOFF;  // see R3
            end
            ST_TURNOFF:
            begin
                next_s.seq_ms = ms_step(s.seq_ms, 1'b0, s.ms_tick);
                // a new request is only seen once back in idle
                if (s.seq_ms > TURNOFF_MS)
                    next_s.st = ST_IDLE;  // see R16
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase
        next_s.cts = (next_s.st == ST_DATA);  // see R2, R3
        next_s.dsr = con_eff;

        // forward detector: on after sync, off 9..10 ms after loss, off under clamp
        next_s.lost_ms = ms_step(s.lost_ms, LINE_SIGNAL | ~s.rlsd, s.ms_tick);
        if (clamp)
            next_s.rlsd = 1'b0;  // see R5
        else if (s.rlsd)
            next_s.rlsd = (s.lost_ms < RLSD_OFF_MS);  // see R3
        else
            next_s.rlsd = SYNC_DONE & LINE_SIGNAL;  // see R1
        next_s.clamp_ms = ms_step(s.clamp_ms, rts_eff, s.ms_tick);

        // received data marks until the detector is on
        if (clamp || !s.rlsd)
            next_s.rx_data = 1'b1;  // see R1, R5
        else if (RX_BIT_VALID)
            next_s.rx_data = descr_out;  // see R13

        // backward channel ready: 120..121 ms after request, off at once
        next_s.b121_ms = ms_step(s.b121_ms, ~p[P_BREQ], s.ms_tick);
        next_s.back_ready = BACK_FITTED & p[P_BREQ] & (s.b121_ms > BACK_ON_MS);  // see R4, R12

        // backward detector: counts while line differs from detector
        next_s.b122_ms = ms_step(s.b122_ms, BACK_LINE_SIGNAL == s.back_rlsd, s.ms_tick);
        if (!BACK_FITTED || bclamp)
            next_s.back_rlsd = 1'b0;  // see R6, R12
        else if (!s.back_rlsd)
            next_s.back_rlsd = BACK_LINE_SIGNAL & (s.b122_ms >= BACK_DET_ON_MS);  // see R4
        else
            next_s.back_rlsd = BACK_LINE_SIGNAL | (s.b122_ms <= BACK_DET_OFF_MS);  // see R4
        next_s.bclamp_ms = ms_step(s.bclamp_ms, p[P_BREQ], s.ms_tick);

        // backward data in both directions
        if (bclamp || !s.back_rlsd)
            next_s.back_rx_data = 1'b1;  // see R6
        else if (BACK_RX_VALID)
            next_s.back_rx_data = BACK_RX_BIT;
        next_s.back_tx_bit = s.back_ready ? p[P_BTXD] : 1'b1;  // see R12
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.st <= ST_IDLE;
            s.clamp_ms <= MS_SAT;
            s.bclamp_ms <= MS_SAT;
            s.rx_data <= 1'b1;
            s.back_rx_data <= 1'b1;
            s.back_tx_bit <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    assign RX_DATA = s.rx_data;
    assign CTS = s.cts;
    assign DSR = s.dsr;
    assign RLSD = s.rlsd;
    assign TX_CLK = s.tx_clk;
    assign RX_CLK = s.rx_clk;
    assign BACK_RX_DATA = s.back_rx_data;
    assign BACK_READY = s.back_ready;
    assign BACK_RLSD = s.back_rlsd;
    assign BACK_TX_BIT = s.back_tx_bit;
    assign TX_ACTIVE = (s.st != ST_IDLE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    a_data_after_detect: assert property (!RLSD |=> RX_DATA)  // see R1
        else $error("received data not marking while detector off");
    a_cts_turn_on: assert property ($rose(CTS) |-> $past(s.seq_ms) > $past(turn_on_ms(p[P_SEQ], p[P_RATE])))  // see R2
        else $error("ready-for-sending raised before turn-on delay");
    a_cts_drop: assert property ($fell(rts_eff) && CTS |=> !CTS)  // see R3
        else $error("ready-for-sending not dropped after request off");
    a_rlsd_drop: assert property (RLSD && !LINE_SIGNAL && s.lost_ms >= RLSD_OFF_MS |=> !RLSD)  // see R3
        else $error("detector not dropped after line loss");
    a_back_ready_on: assert property ($rose(BACK_READY) |-> $past(s.b121_ms) > BACK_ON_MS)  // see R4
        else $error("backward ready raised too early");
    a_clamp_rx: assert property (p[P_2W] && rts_eff |=> RX_DATA && !RLSD)  // see R5
        else $error("received path not clamped during transmit");
    a_clamp_back: assert property (p[P_2W] && p[P_BREQ] |=> BACK_RX_DATA && !BACK_RLSD)  // see R6
        else $error("backward received path not clamped");
    a_fault_off: assert property (p[P_RTS_F] || p[P_CON_F] |=> !CTS)  // see R7
        else $error("faulted request line not read as off");
    a_defer_turnoff: assert property (s.st == ST_TURNOFF && s.seq_ms <= TURNOFF_MS |=> s.st != ST_TRAIN)  // see R16
        else $error("request acted on during turn-off");
    a_train_to_data: assert property ($rose(s.st == ST_DATA) |-> $past(s.st) == ST_TRAIN ##0 CTS)  // see R15
        else $error("data state without training");

    c_turn_on: cover property ($rose(CTS));
    c_turn_off_defer: cover property (s.st == ST_TURNOFF && rts_eff ##1 s.st == ST_TURNOFF);
    c_detector_on: cover property ($rose(RLSD));
    c_back_ready: cover property ($rose(BACK_READY));
endmodule

// ===== design/stream_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low reset already synchronised.
 */
`timescale 1ns/1ps
module stream_fifo
#(
    parameter int W = 1,
    parameter int DEPTH = 4
)
(
    input wire logic clk,
    input wire logic rst_n,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t s;
    fifo_t next_s;
    logic push;
    logic pop;

    // handshakes straight from the occupancy count
    assign in_s.ready = (s.cnt != FULL_CNT);
    assign out_s.valid = (s.cnt != '0);
    assign out_s.data = s.mem[s.rd];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    // pointer and count update
    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr] = in_s.data;
            next_s.wr = (s.wr == LAST) ? '0 : s.wr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: next_s.cnt = s.cnt + 1'b1;
            2'b01: next_s.cnt = s.cnt - 1'b1;
            default: next_s.cnt = s.cnt;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    a_fifo_no_over: assert property (@(posedge clk) disable iff (!rst_n) s.cnt <= FULL_CNT)
        else $error("fifo count above depth");
endmodule

// ===== design/stream_if.sv
/*
 * Valid/ready stream carrier between the control block and its FIFO.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 1);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== design/sync_scrambler.sv
/*
 * Self-synchronising scrambler or descrambler, polynomial 1 + x^-6 + x^-7, with a
 * guard that inverts one bit after a run of coincidences at distances 8, 9 and 12.
 * Assumes en pulses once per bit; dout is valid in the cycle of en.
 */
`timescale 1ns/1ps
module sync_scrambler
    import modem_ctl_pkg::*;
#(
    parameter bit DESCR = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic [HIST_W-1:0] hist;  // hist[0] is the latest line bit
        logic [5:0] gcnt;
    } scr_t;

    scr_t s;
    scr_t next_s;
    logic inv;
    logic line;
    logic coincide;

    // guard fires on the bit after the count is reached
    assign inv = (s.gcnt == GUARD_COUNT);  // see R14
    // line bit: scrambled output, or received input when descrambling
    assign dout = din ^ s.hist[5] ^ s.hist[6] ^ inv;  // see R13
    assign line = DESCR ? din : dout;
    // periods 1,2,3,4,6,8,9,12 all repeat at distance 8, 9 or 12
    assign coincide = (line == s.hist[7]) | (line == s.hist[8]) | (line == s.hist[11]);  // see R14

    // history and guard counter
    always_comb
    begin
        next_s = s;
        if (en)
        begin
            next_s.hist = {s.hist[HIST_W-2:0], line};
            if (inv || !coincide)
                next_s.gcnt = '0;
            else
                next_s.gcnt = s.gcnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    a_guard_clear: assert property (@(posedge clk) disable iff (!rst_n) en && inv |=> s.gcnt == '0)  // see R14
        else $error("guard counter not cleared after inversion");
endmodule

// ===== verification/dte_model.sv
/* terminal-side model: link clock on circuit 113 and the terminal's view of data-set-ready
   assumes the bench opens and closes frames with run */
`timescale 1ns/1ps
module dte_model (
    input wire logic run,
    input wire logic dsr,
    input wire logic dsr_fault,
    output logic ext_clk,
    output logic dce_ready
);
    // 320 ns link clock, odd phase, held low between frames
    initial
    begin
        ext_clk = 1'b0;
        #17;
        forever
        begin
            #160;
            ext_clk = run ? ~ext_clk : 1'b0;
        end
    end
    // a faulted data-set-ready reads as off
    assign dce_ready = dsr & ~dsr_fault;
endmodule

// ===== verification/modem_interchange_control_tb.sv
/* bench for the interchange control block: response times, clamps, faults, fifo
   assumes shortened counts: 20 cycles a millisecond, 12 cycles a bit at full rate and 24 at reduced rate */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module modem_interchange_control_tb;
    import modem_ctl_pkg::*;
    localparam int M = 20;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int xr = 0;
    logic clk = 1'b0, rst_n = 1'b0, rts = 1'b0, rf = 1'b0, con = 1'b0, cf = 1'b0, rate = 1'b0, seq = 1'b0;
    logic tw = 1'b0, cle = 1'b0, xs = 1'b0, bq = 1'b0, ls = 1'b0, sd = 1'b0, rv = 1'b0, rb = 1'b0, rdy = 1'b0;
    logic run = 1'b0, zero = 1'b0, xclk, rxd, cts, dsr, rlsd, rxc, txc, bready, brlsd, act, tv, ok;
    modem_interchange_control #(.CYCLES_PER_MS(M), .BIT_CYC_FULL(12), .BIT_CYC_RED(24)) u_dut (
        .SYS_CLK(clk), .RESETN(rst_n), .TX_DATA(rb), .RTS(rts), .RTS_FAULT(rf), .CONNECT(con), .CONNECT_FAULT(cf),
        .RATE_FULL(rate), .EXT_TX_CLK(xclk), .SEQ_LONG(seq), .TWO_WIRE(tw), .CLAMP_EXT_EN(cle), .EXT_CLK_SEL(xs),
        .BACK_TX_DATA(zero), .BACK_REQ(bq), .BACK_CLAMP_EN(zero), .RX_DATA(rxd), .CTS(cts), .DSR(dsr), .RLSD(rlsd),
        .TX_CLK(txc), .RX_CLK(rxc), .BACK_RX_DATA(), .BACK_READY(bready), .BACK_RLSD(brlsd), .LINE_SIGNAL(ls),
        .SYNC_DONE(sd), .RX_BIT_VALID(rv), .RX_BIT(rb), .BACK_LINE_SIGNAL(ls), .BACK_RX_VALID(zero),
        .BACK_RX_BIT(zero), .TX_ACTIVE(act), .TX_LINE_VALID(tv), .TX_LINE_BIT(), .TX_LINE_READY(rdy), .BACK_TX_BIT());
    dte_model u_dte (.run(run), .dsr(dsr), .dsr_fault(cf), .ext_clk(xclk), .dce_ready(ok));
    // 25 MHz system clock
    always #20 clk = ~clk;
    // link clock edges sent by the terminal
    always @(posedge xclk) xr++;
    // cycle ceiling cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic w(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_dsr();
        `CHK("dsr", 1'b1, dsr)
        cf = 1'b1;
        w(4);
        `CHK("dsr fault", 1'b0, dsr)
        `CHK("dte view", 1'b0, ok)
        cf = 1'b0;
        w(4);
    endtask
    task automatic t_cts(logic r, logic s, int d);
        rate = r;
        seq = s;
        rts = 1'b1;
        w(d * M);
        `CHK("cts early", 1'b0, cts)
        `CHK("active", 1'b1, act)
        w(M + 6);
        `CHK("cts on", 1'b1, cts)
        if (s) rf = 1'b1; else rts = 1'b0;
        w(3);
        `CHK("cts off", 1'b0, cts)
        if (!s)
        begin
            rts = 1'b1;
            w((d + 2) * M);
            `CHK("cts defer", 1'b0, cts)
        end
        rts = 1'b0;
        rf = 1'b0;
        w(30 * M);
    endtask
    task automatic t_rlsd();
        sd = 1'b1;
        ls = 1'b1;
        w(3);
        `CHK("rlsd on", 1'b1, rlsd)
        rv = 1'b1;
        w(1);
        rv = 1'b0;
        w(1);
        `CHK("rx clock", 1'b1, rxc)
        `CHK("rx data", 1'b0, rxd)
        ls = 1'b0;
        w(5 * M);
        `CHK("rlsd hold", 1'b1, rlsd)
        w(10 * M);
        `CHK("rlsd off", 1'b0, rlsd)
    endtask
    task automatic t_clamp();
        ls = 1'b1;
        tw = 1'b1;
        cle = 1'b1;
        rts = 1'b1;
        w(5);
        `CHK("rlsd clamp", 1'b0, rlsd)
        `CHK("rx clamp", 1'b1, rxd)
        rts = 1'b0;
        w(120 * M);
        `CHK("rlsd ext", 1'b0, rlsd)
        w(60 * M);
        `CHK("rlsd back", 1'b1, rlsd)
        tw = 1'b0;
    endtask
    task automatic t_back();
        `CHK("brlsd on", 1'b1, brlsd)
        tw = 1'b1;
        bq = 1'b1;
        w(80 * M);
        `CHK("bready early", 1'b0, bready)
        `CHK("brlsd clamp", 1'b0, brlsd)
        w(81 * M);
        `CHK("bready on", 1'b1, bready)
        bq = 1'b0;
        w(2 * M);
        `CHK("bready off", 1'b0, bready)
        tw = 1'b0;
    endtask
    task automatic t_fifo();
        int hi = 0;
        int n = 0;
        repeat (24)
        begin
            hi += txc;
            w(1);
        end
        `CHK("tx clock", 12, hi)
        xs = 1'b1;
        rdy = 1'b1;
        w(8);
        `CHK("fifo empty", 1'b0, tv)
        rdy = 1'b0;
        run = 1'b1;
        w(30);
        run = 1'b0;
        w(8);
        `CHK("fifo held", 1'b1, tv)
        rdy = 1'b1;
        repeat (6)
        begin
            if (tv === 1'b1)
                n++;
            w(1);
        end
        `CHK("fifo bits", xr, n)
        `CHK("fifo drained", 1'b0, tv)
        rdy = 1'b0;
    endtask
    // reset, then each scenario in turn
    initial
    begin
        w(8);
        rst_n = 1'b1;
        w(4);
        `CHK("reset cts", 1'b0, cts)
        `CHK("reset rxd", 1'b1, rxd)
        con = 1'b1;
        w(4);
        t_dsr();
        t_cts(1'b1, 1'b0, 25);
        t_cts(1'b1, 1'b1, 708);
        t_cts(1'b0, 1'b0, 67);
        t_cts(1'b0, 1'b1, 944);
        t_rlsd();
        t_clamp();
        t_back();
        t_fifo();
        close_out();
    end
endmodule
